// ### design/lbps_pkg.sv
// Package of constants, types and helpers for the backplane phase sequencer.
// Assumes a single system clock; shared by the sequencer top and its base clock divider.
package lbps_pkg;

	// Phase and pin geometry.
	localparam int unsigned    LBPS_PHASES      = 8;
	localparam int unsigned    LBPS_PINS        = 22;
	localparam int unsigned    LBPS_PERIOD_W    = 11;

	// Frame divider arithmetic: base period = (divider + offset) * prescale * multiplier.
	localparam logic [3:0]     LBPS_DIV_OFFSET  = 4'h4;
	localparam logic [3:0]     LBPS_FRAME_MUL   = 4'h8;

	// Duty prescale factors for one through eight backplanes.
	localparam logic [4:0]     LBPS_Y_DUTY1     = 5'h10;
	localparam logic [4:0]     LBPS_Y_DUTY2     = 5'h08;
	localparam logic [4:0]     LBPS_Y_DUTY3     = 5'h05;
	localparam logic [4:0]     LBPS_Y_DUTY4     = 5'h04;
	localparam logic [4:0]     LBPS_Y_DUTY5     = 5'h03;
	localparam logic [4:0]     LBPS_Y_DUTY6     = 5'h03;
	localparam logic [4:0]     LBPS_Y_DUTY7     = 5'h02;
	localparam logic [4:0]     LBPS_Y_DUTY8     = 5'h02;

	// Reset values.
	localparam logic [2:0]     LBPS_DUTY_RESET  = 3'h3;
	localparam logic [2:0]     LBPS_PHASE_RESET = 3'h0;

	// Clock source select codes.
	localparam logic           LBPS_SRC_XTAL    = 1'b0;
	localparam logic           LBPS_SRC_ALT     = 1'b1;

	// Drive level codes of the one-third bias ladder (four levels).
	localparam logic [1:0]     LBPS_LVL_V0      = 2'h0;
	localparam logic [1:0]     LBPS_LVL_V1      = 2'h1;
	localparam logic [1:0]     LBPS_LVL_V2      = 2'h2;
	localparam logic [1:0]     LBPS_LVL_V3      = 2'h3;

	typedef enum logic {
		LBPS_SEQ_IDLE = 1'b0,
		LBPS_SEQ_RUN  = 1'b1
	} lbps_seq_t;

	// Returns the duty prescale factor.
	function automatic logic [4:0] lbps_prescale(input logic [2:0] duty);
		logic [4:0] y;
		y = LBPS_Y_DUTY1;
		unique case (duty)
			3'h0: y = LBPS_Y_DUTY1;
			3'h1: y = LBPS_Y_DUTY2;
			3'h2: y = LBPS_Y_DUTY3;
			3'h3: y = LBPS_Y_DUTY4;
			3'h4: y = LBPS_Y_DUTY5;
			3'h5: y = LBPS_Y_DUTY6;
			3'h6: y = LBPS_Y_DUTY7;
			3'h7: y = LBPS_Y_DUTY8;
		endcase
		return y;
	endfunction

	// Returns the base clock period in display clock edges.
	function automatic logic [LBPS_PERIOD_W-1:0] lbps_period(input logic [2:0] duty, input logic [2:0] div);
		logic [LBPS_PERIOD_W-1:0] p;
		p = LBPS_PERIOD_W'({1'b0, div} + LBPS_DIV_OFFSET) * LBPS_PERIOD_W'(lbps_prescale(duty))
			* LBPS_PERIOD_W'(LBPS_FRAME_MUL);
		return p;
	endfunction

endpackage

// ### design/lbps_base_clock.sv
// Base clock divider: selects the display clock and emits base and half-base ticks.
// Assumes both display clock inputs are slow levels synchronous to clk_sys.
`timescale 1ns/100ps
module lbps_base_clock (
	// System clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Display clock sources.
	input  wire logic       xtalClk,
	input  wire logic       altClk,
	input  wire logic       sourceSelect,
	// Configuration.
	input  wire logic       run,
	input  wire logic [2:0] duty,
	input  wire logic [2:0] frameDividerSelect,
	// Ticks.
	output logic            baseTick,
	output logic            halfTick
);
	import lbps_pkg::*;

	logic                     displayClock_reg;
	logic                     displayClockPrev_reg;
	logic                     displayEdge;
	logic [LBPS_PERIOD_W-1:0] count_reg;
	logic [LBPS_PERIOD_W-1:0] period;

	assign displayEdge = displayClock_reg & ~displayClockPrev_reg;
	assign period      = lbps_period(duty, frameDividerSelect);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			displayClock_reg     <= 1'b0;
			displayClockPrev_reg <= 1'b0;
		end else begin
			displayClock_reg     <= (sourceSelect == LBPS_SRC_ALT) ? altClk : xtalClk;
			displayClockPrev_reg <= displayClock_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			count_reg <= '0;
			baseTick  <= 1'b0;
			halfTick  <= 1'b0;
		end else begin
			baseTick <= 1'b0;
			halfTick <= 1'b0;
			if (!run) begin
				count_reg <= '0;
			end else if (displayEdge) begin
				if (count_reg >= period - LBPS_PERIOD_W'(1)) begin
					count_reg <= '0;
					baseTick  <= 1'b1;
				end else begin
					count_reg <= count_reg + LBPS_PERIOD_W'(1);
					halfTick  <= (count_reg == (period >> 1) - LBPS_PERIOD_W'(1));
				end
			end
		end
	end

endmodule // lbps_base_clock

// ### design/lbps_sequencer.sv
// Backplane phase sequencer top: steps phases A to H and drives pin levels.
// Assumes configuration inputs are static registers synchronous to clk_sys.
`timescale 1ns/100ps
module lbps_sequencer #(
	parameter int unsigned NUM_PINS = lbps_pkg::LBPS_PINS
) (
	// System clock and reset.
	input  wire logic                                 clk_sys,
	input  wire logic                                 resetn,
	// Display clock sources.
	input  wire logic                                 xtalClk,
	input  wire logic                                 altClk,
	// Control fields.
	input  wire logic                                 displayGlobalEnable,
	input  wire logic                                 sourceSelect,
	input  wire logic [2:0]                           dutySelect,
	input  wire logic [2:0]                           frameDividerSelect,
	// Per pin configuration.
	input  wire logic [NUM_PINS-1:0]                  pinFunctionEnable,
	input  wire logic [NUM_PINS-1:0]                  backplaneEnableBit,
	input  wire logic [NUM_PINS*lbps_pkg::LBPS_PHASES-1:0] segmentPhaseBits,
	// Pin drive.
	output logic      [2*NUM_PINS-1:0]                pinLevel,
	output logic      [NUM_PINS-1:0]                  pinDriveEn,
	// Status.
	output logic      [lbps_pkg::LBPS_PHASES-1:0]     phaseActive,
	output logic      [2:0]                           currentPhase,
	output logic      [2:0]                           activeDuty,
	output logic                                      frameStart,
	output logic                                      running
);
	import lbps_pkg::*;

	lbps_seq_t                state_reg;
	lbps_seq_t                state_next;
	logic [2:0]               duty_reg;
	logic [2:0]               phase_reg;
	logic [2:0]               phase_next;
	logic                     polarity_reg;
	logic                     baseTick;
	logic                     halfTick;
	logic                     lastPhase;
	logic                     staticMode;
	logic [2*NUM_PINS-1:0]    level_next;
	logic [NUM_PINS-1:0]      driveEn_next;

	lbps_base_clock u_base_clock (
		.clk_sys            (clk_sys),
		.resetn             (resetn),
		.xtalClk            (xtalClk),
		.altClk             (altClk),
		.sourceSelect       (sourceSelect),
		.run                (state_reg == LBPS_SEQ_RUN),
		.duty               (duty_reg),
		.frameDividerSelect (frameDividerSelect),
		.baseTick           (baseTick),
		.halfTick           (halfTick)
	);

	// The last phase index equals the duty code, since the code is count minus one.
	assign lastPhase  = (phase_reg == duty_reg);
	assign staticMode = (duty_reg == 3'h0);

	// Sequencer state: idle while the display is disabled.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			LBPS_SEQ_IDLE: begin
				if (displayGlobalEnable) begin
					state_next = LBPS_SEQ_RUN;
				end
			end
			LBPS_SEQ_RUN: begin
				if (!displayGlobalEnable) begin
					state_next = LBPS_SEQ_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= LBPS_SEQ_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Duty is taken while idle or at a frame boundary so no frame is cut short.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			duty_reg <= LBPS_DUTY_RESET;
		end else if (state_reg == LBPS_SEQ_IDLE || (baseTick && lastPhase)) begin
			duty_reg <= dutySelect;
		end
	end

	// Phase counter advances once per base period and wraps after the last phase.
	always_comb begin
		phase_next = phase_reg;
		if (state_reg == LBPS_SEQ_IDLE) begin
			phase_next = LBPS_PHASE_RESET;
		end else if (baseTick) begin
			phase_next = lastPhase ? LBPS_PHASE_RESET : phase_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_reg <= LBPS_PHASE_RESET;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// Drive polarity flips every half base period to keep the glass free of DC.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			polarity_reg <= 1'b0;
		end else if (state_reg == LBPS_SEQ_IDLE) begin
			polarity_reg <= 1'b0;
		end else if (baseTick || halfTick) begin
			polarity_reg <= ~polarity_reg;
		end
	end

	// Pin level generation on the four-level ladder.
	always_comb begin
		level_next   = '0;
		driveEn_next = '0;
		for (int p = 0; p < NUM_PINS; p++) begin
			logic bitSet;
			logic [1:0] lvl;
			bitSet = segmentPhaseBits[p*LBPS_PHASES + int'(phase_reg)];
			lvl    = LBPS_LVL_V0;
			if (staticMode) begin
				// Static: only the outer levels, two square waves in or out of phase.
				if (backplaneEnableBit[p]) begin
					lvl = polarity_reg ? LBPS_LVL_V3 : LBPS_LVL_V0;
				end else begin
					lvl = (polarity_reg ^ bitSet) ? LBPS_LVL_V3 : LBPS_LVL_V0;
				end
			end else if (backplaneEnableBit[p]) begin
				if (bitSet) begin
					lvl = polarity_reg ? LBPS_LVL_V3 : LBPS_LVL_V0;
				end else begin
					lvl = polarity_reg ? LBPS_LVL_V1 : LBPS_LVL_V2;
				end
			end else begin
				if (bitSet) begin
					lvl = polarity_reg ? LBPS_LVL_V0 : LBPS_LVL_V3;
				end else begin
					lvl = polarity_reg ? LBPS_LVL_V2 : LBPS_LVL_V1;
				end
			end
			if (state_reg == LBPS_SEQ_RUN && pinFunctionEnable[p] && displayGlobalEnable) begin
				driveEn_next[p]      = 1'b1;
				level_next[2*p +: 2] = lvl;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pinLevel   <= '0;
			pinDriveEn <= '0;
		end else begin
			pinLevel   <= level_next;
			pinDriveEn <= driveEn_next;
		end
	end

	// Status outputs.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phaseActive  <= '0;
			currentPhase <= LBPS_PHASE_RESET;
		end else begin
			phaseActive  <= (state_next == LBPS_SEQ_RUN) ? LBPS_PHASES'(1) << phase_next : '0;
			currentPhase <= phase_next;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			activeDuty <= LBPS_DUTY_RESET;
		end else begin
			activeDuty <= duty_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			frameStart <= 1'b0;
		end else begin
			frameStart <= (state_reg == LBPS_SEQ_RUN) && baseTick && lastPhase;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			running <= 1'b0;
		end else begin
			running <= (state_next == LBPS_SEQ_RUN);
		end
	end

endmodule // lbps_sequencer

// ### dv/lbps_sequencer_chk.sv
// Assertions on the sequencer's phase status, frame pulse and pin enables.
// Assumes it is bound to lbps_sequencer.
`timescale 1ns/100ps
module lbps_sequencer_chk #(
	parameter int unsigned NUM_PINS = 22
) (
	input wire logic                               clk_sys,
	input wire logic                               resetn,
	input wire logic                               displayGlobalEnable,
	input wire logic [NUM_PINS-1:0]                pinFunctionEnable,
	input wire logic [NUM_PINS-1:0]                pinDriveEn,
	input wire logic [lbps_pkg::LBPS_PHASES-1:0]   phaseActive,
	input wire logic [2:0]                         currentPhase,
	input wire logic [2:0]                         activeDuty,
	input wire logic                               frameStart,
	input wire logic                               running
);
	import lbps_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_oneHot; running |-> phaseActive == (8'h01 << currentPhase); endproperty
	a_oneHot: assert property (p_oneHot) else $error("phase flags disagree with index");
	property p_idleFlags; !running |-> phaseActive == 8'h00; endproperty
	a_idleFlags: assert property (p_idleFlags) else $error("phase flags while idle");
	property p_inRange; running |-> currentPhase <= activeDuty; endproperty
	a_inRange: assert property (p_inRange) else $error("phase beyond duty");
	property p_step; running && $past(running) && $changed(currentPhase) |->
		currentPhase == (($past(currentPhase) == $past(activeDuty)) ? 3'h0 : $past(currentPhase) + 3'h1); endproperty
	a_step: assert property (p_step) else $error("phase step out of order");
	property p_pulse; frameStart |=> !frameStart; endproperty
	a_pulse: assert property (p_pulse) else $error("frame pulse too long");
	property p_start; $rose(displayGlobalEnable) |-> ##[1:3] running; endproperty
	a_start: assert property (p_start) else $error("no start after enable");
	property p_stop; !displayGlobalEnable |-> ##[1:3] !running; endproperty
	a_stop: assert property (p_stop) else $error("no stop after disable");
	property p_noDrive; !running && !$past(running) |-> pinDriveEn == '0; endproperty
	a_noDrive: assert property (p_noDrive) else $error("pin driven while idle");
	property p_pinGate; (pinDriveEn & ~pinFunctionEnable) == '0; endproperty
	a_pinGate: assert property (p_pinGate) else $error("disabled pin driven");
	property p_dutyHold; running && $past(running) && !frameStart && !$past(frameStart) |-> $stable(activeDuty); endproperty
	a_dutyHold: assert property (p_dutyHold) else $error("duty changed mid frame");
endmodule // lbps_sequencer_chk
bind lbps_sequencer lbps_sequencer_chk #(.NUM_PINS(NUM_PINS)) lbps_sequencer_chk_i (.clk_sys(clk_sys),
	.resetn(resetn), .displayGlobalEnable(displayGlobalEnable), .pinFunctionEnable(pinFunctionEnable),
	.pinDriveEn(pinDriveEn), .phaseActive(phaseActive), .currentPhase(currentPhase),
	.activeDuty(activeDuty), .frameStart(frameStart), .running(running));

// ### dv/lbps_panel_model.sv
// Passive glass model: the voltage across one segment between a frontplane and a backplane pin.
// Assumes level codes 0..3 are evenly spaced steps of the bias ladder.
`timescale 1ns/100ps
module lbps_panel_model #(
	parameter int unsigned NUM_PINS = 22,
	parameter int unsigned SEG_FP   = 2,
	parameter int unsigned SEG_BP   = 0
) (
	input  wire logic [2*NUM_PINS-1:0] pinLevel,
	input  wire logic [NUM_PINS-1:0]   pinDriveEn,
	output logic      [1:0]            segVolt
);
	logic [1:0] fp;
	logic [1:0] bp;
	always_comb begin
		fp = pinLevel[2*SEG_FP +: 2];
		bp = pinLevel[2*SEG_BP +: 2];
		segVolt = (fp > bp) ? fp - bp : bp - fp;
		if (!(pinDriveEn[SEG_FP] && pinDriveEn[SEG_BP])) begin
			segVolt = 2'h0;
		end
	end
endmodule // lbps_panel_model

// ### dv/tb_lbps_sequencer.sv
// Self-checking bench: runs every duty with a matching divider code and checks frames and levels.
// Assumes a free running display clock of one quarter of clk_sys on the selected input.
`timescale 1ns/100ps
module tb_lbps_sequencer;
	import lbps_pkg::*;
	logic        clk_sys = 0, resetn = 0, en = 0, src = 0;
	logic [2:0]  duty = 3'h0, div = 3'h0, currentPhase, activeDuty;
	logic [21:0] pinEn = 22'h000007, bpEn = 22'h000003, pinDriveEn;
	logic [175:0] seg = {152'h0, 8'h01, 8'h02, 8'h01};
	logic [43:0] pinLevel;
	logic [7:0]  phaseActive, lcdCnt = 8'h00;
	logic        frameStart, running;
	logic [1:0]  segVolt;
	int          badCount = 0, nChecks = 0;
	int          yTab[8] = '{16, 8, 5, 4, 3, 3, 2, 2};
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) #5 lcdCnt++;
	lbps_sequencer #(.NUM_PINS(22)) lbps_sequencer_i (.clk_sys(clk_sys), .resetn(resetn),
		.xtalClk(lcdCnt[1] & ~src), .altClk(lcdCnt[1] & src), .displayGlobalEnable(en),
		.sourceSelect(src), .dutySelect(duty), .frameDividerSelect(div), .pinFunctionEnable(pinEn),
		.backplaneEnableBit(bpEn), .segmentPhaseBits(seg), .pinLevel(pinLevel), .pinDriveEn(pinDriveEn),
		.phaseActive(phaseActive), .currentPhase(currentPhase), .activeDuty(activeDuty),
		.frameStart(frameStart), .running(running));
	lbps_panel_model #(.NUM_PINS(22)) lbps_panel_model_i (.pinLevel(pinLevel), .pinDriveEn(pinDriveEn),
		.segVolt(segVolt));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			badCount++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic waitFrame(output int t, output int nch);
		logic [2:0] prev;
		t = 0;
		nch = 0;
		prev = currentPhase;
		do begin
			@(posedge clk_sys) #1;
			t++;
			if (currentPhase !== prev) nch++;
			prev = currentPhase;
		end while (frameStart !== 1'b1 && t < 8000);
		if (t >= 8000) check("frame timeout", 0, 1);
	endtask
	task automatic runMode(input int d);
		int t, nch, base;
		base = yTab[d] * (d + 4) * 8 * 4;
		@(posedge clk_sys) #5;
		en = 0;
		duty = d[2:0];
		div = d[2:0];
		src = d[0];
		repeat (4) @(posedge clk_sys);
		#1;
		check("idle running", running, 0);
		check("idle drive", pinDriveEn, 0);
		check("idle flags", phaseActive, 0);
		#4 en = 1;
		waitFrame(t, nch);
		waitFrame(t, nch);
		check("frame cycles", t, base * (d + 1));
		check("phase steps", nch, (d == 0) ? 0 : d + 1);
		repeat (10) @(posedge clk_sys);
		#1;
		check("run flag", running, 1);
		check("phase A", currentPhase, 0);
		check("flags A", phaseActive, 1);
		check("duty", activeDuty, d);
		check("drive", pinDriveEn, 22'h7);
		check("off pin level", pinLevel[7:6], 0);
		check("lit segment", segVolt, 3);
		if (d > 0) begin
			repeat (base / 4) @(posedge clk_sys);
			#5 duty = ~d[2:0];
			repeat (base * 3 / 4) @(posedge clk_sys);
			#1;
			check("phase B", currentPhase, 1);
			check("dark segment", segVolt, 1);
			check("deferred duty", activeDuty, d);
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		#5 resetn = 1;
		@(posedge clk_sys) #1;
		check("reset duty", activeDuty, 3);
		check("reset phase", currentPhase, 0);
		for (int d = 0; d < 8; d++) runMode(d);
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		badCount++;
		end_of_test();
	end
endmodule // tb_lbps_sequencer
